// file: hdl/pscf_oneshot.sv
// one-shot down counter used for charge and keep-alive windows
`timescale 1ns/1ns
`default_nettype none
module pscf_oneshot (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,   // load and run
    input  wire logic        abort_i,   // stop without done
    input  wire logic [23:0] load_i,    // window length in cycles, at least 1
    output logic             busy_o,    // high for exactly load_i cycles
    output logic             done_o     // one-cycle pulse after the window
);
    logic [23:0] count;  // cycles left in the window

    // counter: start wins over abort, abort over counting
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count  <= 24'h00_0000;
            done_o <= 1'b0;
        end else if (start_i) begin
            count  <= (load_i == 24'h00_0000) ? 24'h00_0001 : load_i;
            done_o <= 1'b0;
        end else if (abort_i) begin
            count  <= 24'h00_0000;
            done_o <= 1'b0;
        end else begin
            done_o <= (count == 24'h00_0001);
            if (count != 24'h00_0000) begin
                count <= count - 24'h00_0001;
            end
        end
    end

    // busy while cycles remain
    assign busy_o = (count != 24'h00_0000);
endmodule
`default_nettype wire

// file: hdl/pscf_params.svh
// constants for the power and serial format configuration bank
`ifndef PSCF_PARAMS_SVH
`define PSCF_PARAMS_SVH

// register offsets
`define PSCF_OFS_SOFTWARE_RESET_BIT       8'h01
`define PSCF_OFS_SLEEP          8'h02
`define PSCF_OFS_POWER_DOWN     8'h05
`define PSCF_OFS_SERIAL_FMT     8'h07

// reset values
`define PSCF_RST_SLEEP          8'h00
`define PSCF_RST_POWER_DOWN     8'h05
`define PSCF_RST_SERIAL_FMT     8'h30

// writable bit masks; unmasked bits read as zero
`define PSCF_MASK_SLEEP         8'hFD
`define PSCF_MASK_POWER_DOWN    8'h3F

// field positions (lsb of each field)
`define PSCF_BIT_SUPPLY_SEL     7
`define PSCF_LSB_REF_QCHG       3
`define PSCF_BIT_BCAST          2
`define PSCF_BIT_SLEEP_EXIT_N   0
`define PSCF_BIT_SOFTWARE_RESET_BIT       0
`define PSCF_LSB_INPUT_CAP_FAST_CHARGE_TIME     4
`define PSCF_LSB_SHDN_POLICY    2
`define PSCF_LSB_KA_TIME        0
`define PSCF_LSB_FORMAT         6
`define PSCF_LSB_WLEN           4
`define PSCF_BIT_FRAME_SYNC_POLARITY      3
`define PSCF_BIT_BIT_CLOCK_POLARITY       2
`define PSCF_BIT_TX_EDGE        1
`define PSCF_BIT_TX_FILL        0

// fixed broadcast target address, and base for strap-derived address
`define PSCF_BCAST_ADDR         7'h4C
`define PSCF_STRAP_BASE_ADDR    7'h4C

// clock rate and nominal times in microseconds
`define PSCF_CLK_MHZ            50
`define PSCF_REF_QCHG0_US       3500
`define PSCF_REF_QCHG1_US       10000
`define PSCF_REF_QCHG2_US       50000
`define PSCF_REF_QCHG3_US       100000
`define PSCF_INCAP_QCHG0_US     2500
`define PSCF_INCAP_QCHG1_US     12500
`define PSCF_INCAP_QCHG2_US     25000
`define PSCF_INCAP_QCHG3_US     50000
`define PSCF_KA_TIME0_US        30000
`define PSCF_KA_TIME1_US        25000
`define PSCF_KA_TIME2_US        10000
`define PSCF_KA_TIME3_US        5000

`endif

// file: hdl/pscf_pkg.sv
// types for the power and serial format configuration bank
package pscf_pkg;
    // frame format codes as stored in the format register
    typedef enum logic [1:0] {
        PSCF_FMT_TDM  = 2'h0,
        PSCF_FMT_I2S  = 2'h1,
        PSCF_FMT_LJ   = 2'h2,
        PSCF_FMT_RSVD = 2'h3
    } pscf_frame_fmt_t;

    // shutdown policy codes
    typedef enum logic [1:0] {
        PSCF_POL_IMMEDIATE = 2'h0,
        PSCF_POL_TIMED     = 2'h1,
        PSCF_POL_CLEAN     = 2'h2,
        PSCF_POL_RSVD      = 2'h3
    } pscf_shdn_policy_t;

    // digital regulator control states
    typedef enum logic [1:0] {
        PSCF_REG_ON,
        PSCF_REG_KEEP,
        PSCF_REG_OFF
    } pscf_reg_state_t;
endpackage

// file: hdl/pscf_regbank.sv
// power, sleep and serial format configuration register bank
//
// Notes on behaviour
// - supply bit picks external or on-chip analog supply
// - reference charge codes give 3.5/10/50/100 ms
// - broadcast bit forces address 1001100, else straps
// - sleep while sleep-exit bit is zero
// - input cap charge codes give 2.5/12.5/25/50 ms
// - policy 0 cuts regulator at shutdown
// - policy 1 keeps regulator until keep-alive expiry or clean finish
// - policy 2 keeps regulator until clean finish
// - keep-alive codes give 30/25/10/5 ms
// - format codes select TDM, I2S, left-justified
// - word length 16/20/24/32, resets to 32
// - polarity bits select standard or inverted
// - transmit edge bit delays launch half period
// - fill bit drives zero or releases unused cycles
// - edge and fill apply to both data pins
// - software reset restores all register defaults
`timescale 1ns/1ns
`default_nettype none
`include "pscf_params.svh"
module pscf_regbank #(
    parameter int unsigned REF_QCHG0_CYC   = `PSCF_REF_QCHG0_US * `PSCF_CLK_MHZ,
    parameter int unsigned REF_QCHG1_CYC   = `PSCF_REF_QCHG1_US * `PSCF_CLK_MHZ,
    parameter int unsigned REF_QCHG2_CYC   = `PSCF_REF_QCHG2_US * `PSCF_CLK_MHZ,
    parameter int unsigned REF_QCHG3_CYC   = `PSCF_REF_QCHG3_US * `PSCF_CLK_MHZ,
    parameter int unsigned INCAP_QCHG0_CYC = `PSCF_INCAP_QCHG0_US * `PSCF_CLK_MHZ,
    parameter int unsigned INCAP_QCHG1_CYC = `PSCF_INCAP_QCHG1_US * `PSCF_CLK_MHZ,
    parameter int unsigned INCAP_QCHG2_CYC = `PSCF_INCAP_QCHG2_US * `PSCF_CLK_MHZ,
    parameter int unsigned INCAP_QCHG3_CYC = `PSCF_INCAP_QCHG3_US * `PSCF_CLK_MHZ,
    parameter int unsigned KA_TIME0_CYC    = `PSCF_KA_TIME0_US * `PSCF_CLK_MHZ,
    parameter int unsigned KA_TIME1_CYC    = `PSCF_KA_TIME1_US * `PSCF_CLK_MHZ,
    parameter int unsigned KA_TIME2_CYC    = `PSCF_KA_TIME2_US * `PSCF_CLK_MHZ,
    parameter int unsigned KA_TIME3_CYC    = `PSCF_KA_TIME3_US * `PSCF_CLK_MHZ
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rst_n_i,
    // register port from the control-port decoder
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [7:0]               reg_addr_i,
    input  wire logic [7:0]               reg_wdata_i,
    output logic      [7:0]               reg_rdata_o,
    // pins
    input  wire logic                     shutdown_pin_n_i,
    input  wire logic [1:0]               addr_strap_i,
    // power sequencing
    input  wire logic                     clean_shutdown_done_i,
    output logic                          analog_supply_internal_o,
    output logic                          sleep_mode_o,
    output logic                          reference_fast_charge_o,
    output logic                          input_cap_fast_charge_o,
    output logic                          digital_core_regulator_en_o,
    output logic      [6:0]               i2c_target_addr_o,
    // serial port settings
    output pscf_pkg::pscf_frame_fmt_t     serial_frame_format_o,
    output logic      [5:0]               serial_word_length_o,
    output logic                          frame_sync_inverted_o,
    output logic                          bit_clock_inverted_o,
    output logic                          launch_on_falling_o,
    // serial data pins, primary and secondary
    input  wire logic [1:0]               tx_data_i,
    input  wire logic                     tx_slot_used_i,
    output logic      [1:0]               sdout_o,
    output logic      [1:0]               sdout_oe_o
);
    logic [7:0] sleep_and_supply_control;    // sleep, supply, charge, broadcast
    logic [7:0] power_down_control;          // charge, policy, keep-alive
    logic [7:0] serial_port_format_control;  // framing settings
    logic       software_reset_bit_wr;                 // software reset request
    logic       sleep_exit_q;                // previous sleep-exit bit
    logic       charge_start;                // leaving sleep
    logic [23:0] ref_load;                   // reference charge length
    logic [23:0] incap_load;                 // input cap charge length
    logic [23:0] ka_load;                    // keep-alive length
    logic       ka_start;                    // keep-alive window begins
    logic       ka_abort;                    // keep-alive cancelled
    logic       ka_busy;                     // keep-alive running
    logic       ka_done;                     // keep-alive expired
    logic       shdn_s1;                     // pin synchroniser stage 1
    logic       shdn_s2;                     // stage 2
    logic       shdn_s3;                     // stage 3
    logic       shdn_n_q;                    // filtered pin level
    logic       shdn_asserted;               // shutdown requested
    logic [6:0] strap_s1;                    // strap sync stage 1
    logic [6:0] strap_s2;                    // strap sync stage 2
    logic [6:0] strap_s3;                    // strap sync stage 3
    logic [6:0] strap_addr_q;                // filtered strap address
    pscf_pkg::pscf_reg_state_t  reg_state;   // regulator state
    pscf_pkg::pscf_shdn_policy_t policy;     // current policy field

    // software reset write with the reset bit set
    assign software_reset_bit_wr = reg_wr_i && (reg_addr_i == `PSCF_OFS_SOFTWARE_RESET_BIT)
                         && reg_wdata_i[`PSCF_BIT_SOFTWARE_RESET_BIT];

    // sleep register; reserved read-only bit kept at zero
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sleep_and_supply_control <= `PSCF_RST_SLEEP;
        end else if (software_reset_bit_wr) begin
            sleep_and_supply_control <= `PSCF_RST_SLEEP;
        end else if (reg_wr_i && reg_addr_i == `PSCF_OFS_SLEEP) begin
            sleep_and_supply_control <= reg_wdata_i & `PSCF_MASK_SLEEP;
        end
    end

    // power-down register; top bits read-only zero
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_down_control <= `PSCF_RST_POWER_DOWN;
        end else if (software_reset_bit_wr) begin
            power_down_control <= `PSCF_RST_POWER_DOWN;
        end else if (reg_wr_i && reg_addr_i == `PSCF_OFS_POWER_DOWN) begin
            power_down_control <= reg_wdata_i & `PSCF_MASK_POWER_DOWN;
        end
    end

    // serial format register, fully writable
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_port_format_control <= `PSCF_RST_SERIAL_FMT;
        end else if (software_reset_bit_wr) begin
            serial_port_format_control <= `PSCF_RST_SERIAL_FMT;
        end else if (reg_wr_i && reg_addr_i == `PSCF_OFS_SERIAL_FMT) begin
            serial_port_format_control <= reg_wdata_i;
        end
    end

    // registered read data; reset bit self-clears so reads zero
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `PSCF_OFS_SLEEP:      reg_rdata_o <= sleep_and_supply_control;
                `PSCF_OFS_POWER_DOWN: reg_rdata_o <= power_down_control;
                `PSCF_OFS_SERIAL_FMT: reg_rdata_o <= serial_port_format_control;
                default:              reg_rdata_o <= 8'h00; // unmapped
            endcase
        end
    end

    // supply source and sleep state
    assign analog_supply_internal_o =
        sleep_and_supply_control[`PSCF_BIT_SUPPLY_SEL];
    assign sleep_mode_o =
        !sleep_and_supply_control[`PSCF_BIT_SLEEP_EXIT_N];

    // edge detect on the sleep-exit bit starts both charge windows
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sleep_exit_q <= 1'b0;
        end else begin
            sleep_exit_q <= sleep_and_supply_control[`PSCF_BIT_SLEEP_EXIT_N];
        end
    end
    assign charge_start = sleep_and_supply_control[`PSCF_BIT_SLEEP_EXIT_N]
                          && !sleep_exit_q;

    // window lengths from the code fields
    always_comb begin
        unique case (sleep_and_supply_control[`PSCF_LSB_REF_QCHG +: 2])
            2'h0: ref_load = 24'(REF_QCHG0_CYC);
            2'h1: ref_load = 24'(REF_QCHG1_CYC);
            2'h2: ref_load = 24'(REF_QCHG2_CYC);
            2'h3: ref_load = 24'(REF_QCHG3_CYC);
        endcase
        unique case (power_down_control[`PSCF_LSB_INPUT_CAP_FAST_CHARGE_TIME +: 2])
            2'h0: incap_load = 24'(INCAP_QCHG0_CYC);
            2'h1: incap_load = 24'(INCAP_QCHG1_CYC);
            2'h2: incap_load = 24'(INCAP_QCHG2_CYC);
            2'h3: incap_load = 24'(INCAP_QCHG3_CYC);
        endcase
        unique case (power_down_control[`PSCF_LSB_KA_TIME +: 2])
            2'h0: ka_load = 24'(KA_TIME0_CYC);
            2'h1: ka_load = 24'(KA_TIME1_CYC);
            2'h2: ka_load = 24'(KA_TIME2_CYC);
            2'h3: ka_load = 24'(KA_TIME3_CYC);
        endcase
    end

    // reference capacitor charge window
    pscf_oneshot u_ref_charge (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .start_i (charge_start),
        .abort_i (sleep_mode_o),
        .load_i  (ref_load),
        .busy_o  (reference_fast_charge_o),
        .done_o  ()
    );

    // input coupling capacitor charge window
    pscf_oneshot u_incap_charge (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .start_i (charge_start),
        .abort_i (sleep_mode_o),
        .load_i  (incap_load),
        .busy_o  (input_cap_fast_charge_o),
        .done_o  ()
    );

    // shutdown pin: three stages, change taken when stages 2 and 3 agree
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shdn_s1  <= 1'b1;
            shdn_s2  <= 1'b1;
            shdn_s3  <= 1'b1;
            shdn_n_q <= 1'b1;
        end else begin
            shdn_s1 <= shutdown_pin_n_i;
            shdn_s2 <= shdn_s1;
            shdn_s3 <= shdn_s2;
            if (shdn_s2 == shdn_s3) begin
                shdn_n_q <= shdn_s3;
            end
        end
    end
    assign shdn_asserted = !shdn_n_q;

    // address straps: same three-stage filter
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_s1     <= `PSCF_STRAP_BASE_ADDR;
            strap_s2     <= `PSCF_STRAP_BASE_ADDR;
            strap_s3     <= `PSCF_STRAP_BASE_ADDR;
            strap_addr_q <= `PSCF_STRAP_BASE_ADDR;
        end else begin
            strap_s1 <= {5'(`PSCF_STRAP_BASE_ADDR >> 2), addr_strap_i};
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            if (strap_s2 == strap_s3) begin
                strap_addr_q <= strap_s3;
            end
        end
    end

    // target address: fixed in broadcast mode, else from straps
    assign i2c_target_addr_o = sleep_and_supply_control[`PSCF_BIT_BCAST] ?
                               `PSCF_BCAST_ADDR : strap_addr_q;

    // digital regulator control
    assign policy = pscf_pkg::pscf_shdn_policy_t'(
                        power_down_control[`PSCF_LSB_SHDN_POLICY +: 2]);
    assign ka_start = (reg_state == pscf_pkg::PSCF_REG_ON) && shdn_asserted
                      && (policy == pscf_pkg::PSCF_POL_TIMED
                          || policy == pscf_pkg::PSCF_POL_RSVD);
    assign ka_abort = (reg_state != pscf_pkg::PSCF_REG_KEEP) || !shdn_asserted;

    // keep-alive window
    pscf_oneshot u_keep_alive (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .start_i (ka_start),
        .abort_i (ka_abort),
        .load_i  (ka_load),
        .busy_o  (ka_busy),
        .done_o  (ka_done)
    );

    // regulator state machine; reserved policy treated as timed
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_state <= pscf_pkg::PSCF_REG_ON;
        end else begin
            unique case (reg_state)
                pscf_pkg::PSCF_REG_ON: begin
                    if (shdn_asserted) begin
                        if (policy == pscf_pkg::PSCF_POL_IMMEDIATE) begin
                            reg_state <= pscf_pkg::PSCF_REG_OFF;
                        end else begin
                            reg_state <= pscf_pkg::PSCF_REG_KEEP;
                        end
                    end
                end
                pscf_pkg::PSCF_REG_KEEP: begin
                    if (!shdn_asserted) begin
                        reg_state <= pscf_pkg::PSCF_REG_ON;
                    end else if (clean_shutdown_done_i) begin
                        reg_state <= pscf_pkg::PSCF_REG_OFF;
                    end else if (ka_done && policy != pscf_pkg::PSCF_POL_CLEAN) begin
                        reg_state <= pscf_pkg::PSCF_REG_OFF;
                    end
                end
                pscf_pkg::PSCF_REG_OFF: begin
                    if (!shdn_asserted) begin
                        reg_state <= pscf_pkg::PSCF_REG_ON;
                    end
                end
                default: reg_state <= pscf_pkg::PSCF_REG_ON; // unused code
            endcase
        end
    end
    assign digital_core_regulator_en_o = (reg_state != pscf_pkg::PSCF_REG_OFF);

    // decoded serial settings, static between writes
    assign serial_frame_format_o = pscf_pkg::pscf_frame_fmt_t'(
        serial_port_format_control[`PSCF_LSB_FORMAT +: 2]);
    always_comb begin
        unique case (serial_port_format_control[`PSCF_LSB_WLEN +: 2])
            2'h0: serial_word_length_o = 6'd16;
            2'h1: serial_word_length_o = 6'd20;
            2'h2: serial_word_length_o = 6'd24;
            2'h3: serial_word_length_o = 6'd32;
        endcase
    end
    assign frame_sync_inverted_o =
        serial_port_format_control[`PSCF_BIT_FRAME_SYNC_POLARITY];
    assign bit_clock_inverted_o  =
        serial_port_format_control[`PSCF_BIT_BIT_CLOCK_POLARITY];
    // standard launch is the falling edge; each bit flips it
    assign launch_on_falling_o = !(serial_port_format_control[`PSCF_BIT_BIT_CLOCK_POLARITY]
                                   ^ serial_port_format_control[`PSCF_BIT_TX_EDGE]);

    // both data pins share one fill policy for unused cycles
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdout_o    <= 2'h0;
            sdout_oe_o <= 2'h0;
        end else if (tx_slot_used_i) begin
            sdout_o    <= tx_data_i;
            sdout_oe_o <= 2'h3;
        end else begin
            sdout_o    <= 2'h0;
            sdout_oe_o <= {2{!serial_port_format_control[`PSCF_BIT_TX_FILL]}};
        end
    end

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_supply_sel;
        reg_wr_i && !software_reset_bit_wr && reg_addr_i == `PSCF_OFS_SLEEP
            |=> analog_supply_internal_o == $past(reg_wdata_i[7]);
    endproperty
    a_supply_sel: assert property (p_supply_sel) else $error("supply select wrong");

    property p_charge_start;
        charge_start |=> reference_fast_charge_o && input_cap_fast_charge_o;
    endproperty
    a_charge_start: assert property (p_charge_start) else $error("charge not started");

    property p_bcast;
        sleep_and_supply_control[`PSCF_BIT_BCAST] |-> i2c_target_addr_o == 7'h4C;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast address wrong");

    property p_sleep;
        reg_wr_i && reg_addr_i == `PSCF_OFS_SLEEP && !reg_wdata_i[0]
            |=> sleep_mode_o;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");

    property p_immediate_off;
        reg_state == pscf_pkg::PSCF_REG_ON && shdn_asserted
            && policy == pscf_pkg::PSCF_POL_IMMEDIATE |=> !digital_core_regulator_en_o;
    endproperty
    a_immediate_off: assert property (p_immediate_off) else $error("regulator stayed on");

    property p_timed_keep;
        reg_state == pscf_pkg::PSCF_REG_ON && shdn_asserted
            && policy == pscf_pkg::PSCF_POL_TIMED |=> digital_core_regulator_en_o
            ##1 (digital_core_regulator_en_o || $past(clean_shutdown_done_i));
    endproperty
    a_timed_keep: assert property (p_timed_keep) else $error("keep-alive cut short");

    property p_clean_keep;
        reg_state == pscf_pkg::PSCF_REG_KEEP && policy == pscf_pkg::PSCF_POL_CLEAN
            && !clean_shutdown_done_i |=> digital_core_regulator_en_o;
    endproperty
    a_clean_keep: assert property (p_clean_keep) else $error("regulator cut early");

    property p_wlen;
        reg_wr_i && !software_reset_bit_wr && reg_addr_i == `PSCF_OFS_SERIAL_FMT
            && reg_wdata_i[5:4] == 2'h0 |=> serial_word_length_o == 6'd16;
    endproperty
    a_wlen: assert property (p_wlen) else $error("word length wrong");

    property p_fill;
        !tx_slot_used_i |=> sdout_o == 2'h0
            && sdout_oe_o == {2{!$past(serial_port_format_control[0])}};
    endproperty
    a_fill: assert property (p_fill) else $error("unused cycle fill wrong");

    property p_software_reset_bit;
        software_reset_bit_wr |=> serial_port_format_control == 8'h30
            && power_down_control == 8'h05 && sleep_and_supply_control == 8'h00;
    endproperty
    a_software_reset_bit: assert property (p_software_reset_bit) else $error("software reset incomplete");

    c_leave_sleep: cover property (charge_start);
    c_keep_expire: cover property (reg_state == pscf_pkg::PSCF_REG_KEEP && ka_done);
    c_clean_off:   cover property (reg_state == pscf_pkg::PSCF_REG_KEEP
                                   && clean_shutdown_done_i && shdn_asserted);
endmodule
`default_nettype wire

// file: testbench/power_and_serial_format_config_test.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "pscf_params.svh"
module power_and_serial_format_config_test;
    logic mclk_i, rst_n_i, reg_wr_i, reg_rd_i, shutdown_pin_n_i, clean_shutdown_done_i;
    logic tx_slot_used_i, analog_supply_internal_o, sleep_mode_o, reference_fast_charge_o;
    logic input_cap_fast_charge_o, digital_core_regulator_en_o, frame_sync_inverted_o;
    logic bit_clock_inverted_o, launch_on_falling_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [1:0] addr_strap_i, tx_data_i, sdout_o, sdout_oe_o;
    logic [6:0] i2c_target_addr_o;
    logic [5:0] serial_word_length_o;
    pscf_pkg::pscf_frame_fmt_t serial_frame_format_o;
    int num_errors = 0, n_compared = 0, k, cr = 0, ci = 0;
    pscf_regbank #(.REF_QCHG0_CYC(12), .INCAP_QCHG0_CYC(16), .KA_TIME1_CYC(40)) dut (.*);
    pscf_host host (.mclk_i, .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
                    .wdata_o(reg_wdata_i));
    // clock and charge-window length counters
    initial begin
        mclk_i = 0;
        forever #10 mclk_i = !mclk_i;
    end
    always @(posedge mclk_i) begin
        cr += reference_fast_charge_o;
        ci += input_cap_fast_charge_o;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.acc(0, a, 8'h00);
        chk(reg_rdata_o, e);
    endtask
    task automatic end_of_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
    initial begin
        {rst_n_i, clean_shutdown_done_i, tx_slot_used_i} = 3'b000;
        shutdown_pin_n_i = 1;
        tx_data_i = 2'b10;
        addr_strap_i = 2'b11;
        host.wr_o = 0;
        host.rd_o = 0;
        host.addr_o = 0;
        host.wdata_o = 0;
        repeat (4) @(negedge mclk_i);
        rst_n_i = 1;
        rd(`PSCF_OFS_SLEEP, 8'h00);
        rd(`PSCF_OFS_POWER_DOWN, 8'h05);
        rd(`PSCF_OFS_SERIAL_FMT, 8'h30);
        chk(sleep_mode_o, 1);
        chk(i2c_target_addr_o, 8'h4F);
        // every code of every format field
        for (k = 0; k < 4; k++) begin
            host.acc(1, `PSCF_OFS_SERIAL_FMT, 8'(k * 8'h55));
            chk(serial_frame_format_o, 8'(k));
            chk(serial_word_length_o, 8'(k == 3 ? 32 : 16 + 4 * k));
            chk({frame_sync_inverted_o, bit_clock_inverted_o}, 8'(k));
            chk(launch_on_falling_o, !(k[0] ^ k[1]));
            chk(sdout_oe_o, {2{!k[0]}});
            rd(`PSCF_OFS_SERIAL_FMT, 8'(k * 8'h55));
        end
        tx_slot_used_i = 1;
        repeat (2) @(negedge mclk_i);
        chk({sdout_oe_o, sdout_o}, 8'h0E);
        cr = 0;
        ci = 0;
        host.acc(1, `PSCF_OFS_SLEEP, 8'h87);
        chk({analog_supply_internal_o, sleep_mode_o}, 8'h02);
        chk(i2c_target_addr_o, 8'h4C);
        rd(`PSCF_OFS_SLEEP, 8'h85);
        repeat (30) @(negedge mclk_i);
        chk(8'(cr), 8'd12);
        chk(8'(ci), 8'd16);
        rd(8'h03, 8'h00);
        // default timed policy, then immediate, then clean
        shutdown_pin_n_i = 0;
        repeat (30) @(negedge mclk_i);
        chk(digital_core_regulator_en_o, 1);
        repeat (30) @(negedge mclk_i);
        chk(digital_core_regulator_en_o, 0);
        shutdown_pin_n_i = 1;
        host.acc(1, `PSCF_OFS_POWER_DOWN, 8'h01);
        repeat (10) @(negedge mclk_i);
        shutdown_pin_n_i = 0;
        repeat (10) @(negedge mclk_i);
        chk(digital_core_regulator_en_o, 0);
        shutdown_pin_n_i = 1;
        host.acc(1, `PSCF_OFS_POWER_DOWN, 8'hC9);
        rd(`PSCF_OFS_POWER_DOWN, 8'h09);
        shutdown_pin_n_i = 0;
        repeat (60) @(negedge mclk_i);
        chk(digital_core_regulator_en_o, 1);
        clean_shutdown_done_i = 1;
        repeat (3) @(negedge mclk_i);
        chk(digital_core_regulator_en_o, 0);
        host.acc(1, 8'h01, 8'h01);
        rd(`PSCF_OFS_SERIAL_FMT, 8'h30);
        rd(8'h01, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire

// file: testbench/pscf_host.sv
// host model that drives the register port of the bank
`timescale 1ns/1ns
`default_nettype none
module pscf_host (
    input  wire logic       mclk_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    // one access: strobe for one edge, then one idle cycle
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        wr_o = w;
        rd_o = !w;
        addr_o = a;
        wdata_o = d;
        @(negedge mclk_i);
        wr_o = 0;
        rd_o = 0;
        @(negedge mclk_i);
    endtask
endmodule
`default_nettype wire
